//--- bench/ops_sva.sv
`timescale 1ns/1ps
`include "op_consts.vh"
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module ops_sva (
  // clock, reset, decode
  input wire               ref_clk, rst, op_valid, dest_sel, busy,
  input wire [`OP_W-1:0]   op_code,
  // results
  input wire               push_q, pc_load_q, discard_next_q, null_we_q,
  input wire               null_result_flag_q, acc_we_q, file_we_q,
  input wire               watchdog_clear_q, timeout_flag_set_q,
  input wire               sleep_entry_flag_set_q,
  input wire [`DATA_W-1:0] acc_wdata_q, file_wdata_q
);
  wire take = op_valid && !busy;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_call_two_step: assert property (
    take && op_code == `OP_CALL_ACC |=> push_q && busy ##1 pc_load_q && !busy)
    else $error("call push then load broken");
  a_call_flags_kept: assert property (
    push_q |-> !null_we_q ##1 !null_we_q) else $error("call touched flag");
  a_clear_file: assert property (
    take && op_code == `OP_CLR_FILE |=> file_we_q && file_wdata_q == 8'h00
    && null_we_q && null_result_flag_q) else $error("file clear wrong");
  a_clear_acc: assert property (
    take && op_code == `OP_CLR_ACC |=> acc_we_q && acc_wdata_q == 8'h00
    && null_we_q && null_result_flag_q) else $error("acc clear wrong");
  a_kick_flags: assert property (
    take && op_code == `OP_KICK_WDT |=> watchdog_clear_q && timeout_flag_set_q
    && sleep_entry_flag_set_q) else $error("watchdog kick wrong");
  a_comp_dest: assert property (
    take && op_code == `OP_COMP_FILE |=> acc_we_q == !$past(dest_sel)
    && file_we_q == $past(dest_sel)) else $error("complement routing");
  a_null_match: assert property (
    null_we_q |-> null_result_flag_q == (acc_we_q ? acc_wdata_q == 8'h00
    : file_wdata_q == 8'h00)) else $error("null flag mismatch");
  a_skip_zero: assert property (
    discard_next_q |-> busy && ((acc_we_q && acc_wdata_q == 8'h00) ||
    (file_we_q && file_wdata_q == 8'h00))) else $error("bad discard");
endmodule // ops_sva
bind call_clear_decrement_ops ops_sva ops_sva_i (
  .ref_clk                (ref_clk),
  .rst                    (rst),
  .op_valid               (op_valid),
  .dest_sel               (dest_sel),
  .busy                   (busy),
  .op_code                (op_code),
  .push_q                 (push_q),
  .pc_load_q              (pc_load_q),
  .discard_next_q         (discard_next_q),
  .null_we_q              (null_we_q),
  .null_result_flag_q     (null_result_flag_q),
  .acc_we_q               (acc_we_q),
  .file_we_q              (file_we_q),
  .watchdog_clear_q       (watchdog_clear_q),
  .timeout_flag_set_q     (timeout_flag_set_q),
  .sleep_entry_flag_set_q (sleep_entry_flag_set_q),
  .acc_wdata_q            (acc_wdata_q),
  .file_wdata_q           (file_wdata_q)
);

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  reg        ref_clk = 0, rst = 1, op_valid = 0, dest_sel = 0;
  reg [2:0]  op_code = 0;
  reg [6:0]  file_addr = 7'h7f, pc_upper_latch = 7'h55;
  reg [7:0]  file_rdata = 0, acc_in = 8'h34;
  reg [14:0] pc_in = 15'h10ff;
  wire       busy, file_we_q, acc_we_q, null_we_q, null_result_flag_q, push_q;
  wire       pc_load_q, discard_next_q, watchdog_clear_q;
  wire       timeout_flag_set_q, sleep_entry_flag_set_q;
  wire [6:0] file_waddr_q;
  wire [7:0] file_wdata_q, acc_wdata_q;
  wire [14:0] stack_top_q, pc_new_q;
  int n_errors = 0, n_tests = 0;
  reg [2:0] o;
  reg d, z;
  reg [7:0] r, e;
  // op, dest, operand, expected result, expected null flag
  reg [20:0] rows [8] = '{{3'h5,1'b0,8'hff,8'h00,1'b1},
    {3'h5,1'b1,8'h5a,8'ha5,1'b0}, {3'h6,1'b0,8'h01,8'h00,1'b1},
    {3'h6,1'b1,8'h00,8'hff,1'b0}, {3'h7,1'b0,8'h00,8'hff,1'b0},
    {3'h7,1'b1,8'h02,8'h01,1'b0}, {3'h2,1'b1,8'h5a,8'h00,1'b1},
    {3'h3,1'b0,8'h5a,8'h00,1'b1}};
  call_clear_decrement_ops call_clear_decrement_ops_i (
    .ref_clk                (ref_clk),
    .rst                    (rst),
    .op_valid               (op_valid),
    .op_code                (op_code),
    .file_addr              (file_addr),
    .dest_sel               (dest_sel),
    .file_rdata             (file_rdata),
    .acc_in                 (acc_in),
    .pc_in                  (pc_in),
    .pc_upper_latch         (pc_upper_latch),
    .busy                   (busy),
    .file_we_q              (file_we_q),
    .file_waddr_q           (file_waddr_q),
    .file_wdata_q           (file_wdata_q),
    .acc_we_q               (acc_we_q),
    .acc_wdata_q            (acc_wdata_q),
    .null_we_q              (null_we_q),
    .null_result_flag_q     (null_result_flag_q),
    .push_q                 (push_q),
    .stack_top_q            (stack_top_q),
    .pc_load_q              (pc_load_q),
    .pc_new_q               (pc_new_q),
    .discard_next_q         (discard_next_q),
    .watchdog_clear_q       (watchdog_clear_q),
    .timeout_flag_set_q     (timeout_flag_set_q),
    .sleep_entry_flag_set_q (sleep_entry_flag_set_q)
  );
  always #5 ref_clk = ~ref_clk;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task issue(input [2:0] oc, input dd, input [7:0] rd);
    @(posedge ref_clk);
    op_valid <= 1;
    op_code <= oc;
    dest_sel <= dd;
    file_rdata <= rd;
    @(posedge ref_clk);
    op_valid <= 0;
    #1;
  endtask
  // second request held during busy must be ignored
  task two(input [2:0] oc, input [7:0] rd);
    @(posedge ref_clk);
    op_valid <= 1;
    op_code <= oc;
    dest_sel <= 1;
    file_rdata <= rd;
    @(posedge ref_clk);
    op_code <= 3'h3;
    #1;
  endtask
  task wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    #100000;
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    chk({busy, push_q, acc_we_q, file_we_q}, 4'h0);
    rst <= 0;
    foreach (rows[i]) begin
      {o, d, r, e, z} = rows[i];
      issue(o, d, r);
      chk(d ? file_wdata_q : acc_wdata_q, e);
      chk({file_we_q, acc_we_q}, {d, !d});
      if (d) chk(file_waddr_q, 7'h7f);
      if (o != 3'h7) chk({null_we_q, null_result_flag_q}, {1'b1, z});
      chk(discard_next_q, 0);
      $display("row %0d done", i);
    end
    two(3'h1, 8'h00);
    chk({push_q, busy, stack_top_q}, {2'b11, 15'h1100});
    @(posedge ref_clk);
    op_valid <= 0;
    #1;
    chk({pc_load_q, pc_new_q}, {1'b1, 7'h55, 8'h34});
    chk({acc_we_q, null_we_q}, 0);
    $display("call done");
    two(3'h7, 8'h01);
    chk({discard_next_q, busy, file_we_q, file_wdata_q}, 11'h700);
    @(posedge ref_clk);
    op_valid <= 0;
    #1;
    chk({acc_we_q, discard_next_q, busy}, 0);
    $display("zero skip done");
    issue(3'h4, 0, 0);
    chk(watchdog_clear_q, 1);
    chk({timeout_flag_set_q, sleep_entry_flag_set_q}, 2'b11);
    // reset in mid-run also clears the held data words
    @(posedge ref_clk);
    rst <= 1'h1;
    #1;
    chk({watchdog_clear_q, busy, stack_top_q, pc_new_q}, 32'h0);
    chk({timeout_flag_set_q, null_result_flag_q}, 2'h0);
    @(posedge ref_clk);
    rst <= 1'h0;
    $display("kick and reset done");
    issue(3'h3, 1'h0, 8'h00);
    chk({acc_we_q, null_we_q, null_result_flag_q}, 3'h7);
    chk(acc_wdata_q, 8'h00);
    $display("reset release done");
    wrap_up;
  end
endmodule // tb

//--- hw/call_clear_decrement_ops.v
// How it works
// RULE1: call via accumulator pushes pc plus one to stack top first.
// RULE2: call loads accumulator to pc low, latch bits to pc high.
// RULE3: call takes two cycles and leaves status flags alone.
// RULE4: clear file register writes zero to address 0..127, sets null flag.
// RULE5: clear accumulator writes zero to accumulator, sets null flag.
// RULE6: watchdog kick zeroes watchdog counter and its prescaler.
// RULE7: watchdog kick sets active-low timeout and sleep flags to one.
// RULE8: complement inverts file register, null flag from result.
// RULE9: complement goes to accumulator on dest 0, file on dest 1.
// RULE10: decrement file, dest select routes result, null flag updated.
// RULE11: decrement-skip subtracts one, result routed by dest select.
// RULE12: zero decrement-skip result turns next instruction into a nop.
// RULE13: null flag set when 8-bit result is zero, else cleared.
`timescale 1ns/1ps
`include "op_consts.vh"
module call_clear_decrement_ops (
  // clock and reset
  input  wire                ref_clk,
  input  wire                rst,
  // decoded instruction, one cycle per instruction, two for call and zero skip
  input  wire                op_valid,
  input  wire [`OP_W-1:0]    op_code,
  input  wire [`ADDR_W-1:0]  file_addr,
  input  wire                dest_sel,
  // core state read
  input  wire [`DATA_W-1:0]  file_rdata,
  input  wire [`DATA_W-1:0]  acc_in,
  input  wire [`PC_W-1:0]    pc_in,
  input  wire [`LATCH_W-1:0] pc_upper_latch,
  // busy: sequencer holds the next instruction
  output wire                busy,
  // file register write
  output reg                 file_we_q,
  output reg  [`ADDR_W-1:0]  file_waddr_q,
  output reg  [`DATA_W-1:0]  file_wdata_q,
  // accumulator write
  output reg                 acc_we_q,
  output reg  [`DATA_W-1:0]  acc_wdata_q,
  // null result flag write
  output reg                 null_we_q,
  output reg                 null_result_flag_q,
  // return stack push
  output reg                 push_q,
  output reg  [`PC_W-1:0]    stack_top_q,
  // program counter load
  output reg                 pc_load_q,
  output reg  [`PC_W-1:0]    pc_new_q,
  // next fetched instruction to be discarded
  output reg                 discard_next_q,
  // watchdog
  output reg                 watchdog_clear_q,
  output reg                 timeout_flag_set_q,
  output reg                 sleep_entry_flag_set_q
);
  // ------------------------------------------------------------
  // result path
  // ------------------------------------------------------------
  wire [`DATA_W-1:0] alu_result;
  wire               alu_zero;

  result_alu u_alu (
    .op      (op_code),
    .operand (file_rdata),
    .result  (alu_result),
    .is_zero (alu_zero)
  );

  // ------------------------------------------------------------
  // states and decode
  // ------------------------------------------------------------
  localparam [0:0] ST_IDLE   = 1'h0;
  localparam [0:0] ST_SECOND = 1'h1;

  reg             state_q;
  reg             state_d;
  reg [`PC_W-1:0] target_q;
  reg [`PC_W-1:0] target_d;

  // a new instruction is only taken in the idle state
  wire take        = op_valid & (state_q == ST_IDLE);
  wire is_call     = take & (op_code == `OP_CALL_ACC);
  wire is_clr_file = take & (op_code == `OP_CLR_FILE);
  wire is_clr_acc  = take & (op_code == `OP_CLR_ACC);
  wire is_kick     = take & (op_code == `OP_KICK_WDT);
  wire is_comp     = take & (op_code == `OP_COMP_FILE);
  wire is_dec      = take & (op_code == `OP_DEC_FILE);
  wire is_skip     = take & (op_code == `OP_DEC_SKIP);
  // alu results that follow the destination select
  wire is_routed   = is_comp | is_dec | is_skip;
  wire to_acc      = (dest_sel == `DEST_ACC);
  wire skip_hit    = is_skip & alu_zero;

  // ------------------------------------------------------------
  // two-cycle sequencing
  // ------------------------------------------------------------
  // second cycle of call or skip nop blocks new instructions
  assign busy = (state_q == ST_SECOND);

  always @* begin
    state_d  = state_q;
    target_d = target_q;
    case (state_q)
      ST_IDLE: begin
        if (is_call) begin
          state_d  = ST_SECOND;
          // RULE2: pc from latch and acc
          target_d = {pc_upper_latch, acc_in};
        end else if (skip_hit) begin
          // RULE12: second cycle is nop
          state_d = ST_SECOND;
        end
      end
      ST_SECOND: state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q  <= ST_IDLE;
      target_q <= `PC_ZERO;
    end else begin
      state_q  <= state_d;
      target_q <= target_d;
    end
  end

  // ------------------------------------------------------------
  // file register write
  // ------------------------------------------------------------
  reg               file_we_d;
  reg [`ADDR_W-1:0] file_waddr_d;
  reg [`DATA_W-1:0] file_wdata_d;

  always @* begin
    file_we_d    = `FLAG_CLR;
    file_waddr_d = file_waddr_q;
    file_wdata_d = file_wdata_q;
    if (is_clr_file) begin
      // RULE4: zero addressed file
      file_we_d    = `FLAG_SET;
      file_waddr_d = file_addr;
      file_wdata_d = `DATA_ZERO;
    end else if (is_routed && !to_acc) begin
      // RULE9: result back to file
      // RULE11: skip result too
      file_we_d    = `FLAG_SET;
      file_waddr_d = file_addr;
      file_wdata_d = alu_result;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      file_we_q    <= `FLAG_CLR;
      file_waddr_q <= `ADDR_ZERO;
      file_wdata_q <= `DATA_ZERO;
    end else begin
      file_we_q    <= file_we_d;
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
    end
  end

  // ------------------------------------------------------------
  // accumulator write
  // ------------------------------------------------------------
  reg               acc_we_d;
  reg [`DATA_W-1:0] acc_wdata_d;

  always @* begin
    acc_we_d    = `FLAG_CLR;
    acc_wdata_d = acc_wdata_q;
    if (is_clr_acc) begin
      // RULE5: zero accumulator
      acc_we_d    = `FLAG_SET;
      acc_wdata_d = `DATA_ZERO;
    end else if (is_routed && to_acc) begin
      // RULE10: result to accumulator
      // RULE11: skip result too
      acc_we_d    = `FLAG_SET;
      acc_wdata_d = alu_result;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_we_q    <= `FLAG_CLR;
      acc_wdata_q <= `DATA_ZERO;
    end else begin
      acc_we_q    <= acc_we_d;
      acc_wdata_q <= acc_wdata_d;
    end
  end

  // ------------------------------------------------------------
  // null result flag
  // ------------------------------------------------------------
  // the skip form leaves the flag as it was
  reg null_we_d;
  reg null_result_flag_d;

  always @* begin
    null_we_d          = `FLAG_CLR;
    null_result_flag_d = null_result_flag_q;
    if (is_clr_file || is_clr_acc) begin
      // RULE5: clears always set it
      null_we_d          = `FLAG_SET;
      null_result_flag_d = `FLAG_SET;
    end else if (is_comp || is_dec) begin
      // RULE8: flag from result
      // RULE13: set on zero
      null_we_d          = `FLAG_SET;
      null_result_flag_d = alu_zero;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      null_we_q          <= `FLAG_CLR;
      null_result_flag_q <= `FLAG_CLR;
    end else begin
      null_we_q          <= null_we_d;
      null_result_flag_q <= null_result_flag_d;
    end
  end

  // ------------------------------------------------------------
  // return stack and program counter
  // ------------------------------------------------------------
  reg             push_d;
  reg [`PC_W-1:0] stack_top_d;
  reg             pc_load_d;
  reg [`PC_W-1:0] pc_new_d;

  always @* begin
    push_d      = `FLAG_CLR;
    stack_top_d = stack_top_q;
    pc_load_d   = `FLAG_CLR;
    pc_new_d    = pc_new_q;
    if (is_call) begin
      // RULE1: push return address first
      push_d      = `FLAG_SET;
      stack_top_d = pc_in + `PC_ONE;
    end
    // RULE3: pc moves in the second cycle
    if (state_q == ST_SECOND && push_q) begin
      // RULE2: load pc after push
      pc_load_d = `FLAG_SET;
      pc_new_d  = target_q;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      push_q      <= `FLAG_CLR;
      stack_top_q <= `PC_ZERO;
      pc_load_q   <= `FLAG_CLR;
      pc_new_q    <= `PC_ZERO;
    end else begin
      push_q      <= push_d;
      stack_top_q <= stack_top_d;
      pc_load_q   <= pc_load_d;
      pc_new_q    <= pc_new_d;
    end
  end

  // ------------------------------------------------------------
  // skip on zero
  // ------------------------------------------------------------
  // the prefetched word is dropped by the sequencer, not here
  reg discard_next_d;

  always @* begin
    discard_next_d = `FLAG_CLR;
    if (skip_hit) begin
      // RULE12: flush prefetched word
      discard_next_d = `FLAG_SET;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      discard_next_q <= `FLAG_CLR;
    end else begin
      discard_next_q <= discard_next_d;
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  reg watchdog_clear_d;
  reg timeout_flag_set_d;
  reg sleep_entry_flag_set_d;

  always @* begin
    // RULE6: clear counter and prescaler
    watchdog_clear_d       = is_kick;
    // RULE7: set both active-low flags
    timeout_flag_set_d     = is_kick;
    sleep_entry_flag_set_d = is_kick;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      watchdog_clear_q       <= `FLAG_CLR;
      timeout_flag_set_q     <= `FLAG_CLR;
      sleep_entry_flag_set_q <= `FLAG_CLR;
    end else begin
      watchdog_clear_q       <= watchdog_clear_d;
      timeout_flag_set_q     <= timeout_flag_set_d;
      sleep_entry_flag_set_q <= sleep_entry_flag_set_d;
    end
  end
endmodule // call_clear_decrement_ops

//--- hw/op_consts.vh
`ifndef OP_CONSTS_VH
`define OP_CONSTS_VH
// ------------------------------------------------------------
// operation codes on op_code
// ------------------------------------------------------------
`define OP_W           3
`define OP_NONE        3'h0
`define OP_CALL_ACC    3'h1
`define OP_CLR_FILE    3'h2
`define OP_CLR_ACC     3'h3
`define OP_KICK_WDT    3'h4
`define OP_COMP_FILE   3'h5
`define OP_DEC_FILE    3'h6
`define OP_DEC_SKIP    3'h7
// ------------------------------------------------------------
// widths and values
// ------------------------------------------------------------
`define DATA_W         8
`define ADDR_W         7
`define PC_W           15
`define PCL_HI         7
`define LATCH_W        7
`define DATA_ZERO      8'h00
`define DATA_ONE       8'h01
`define PC_ZERO        15'h0000
`define PC_ONE         15'h0001
`define ADDR_ZERO      7'h00
`define DEST_ACC       1'h0
`define FLAG_SET       1'h1
`define FLAG_CLR       1'h0
`endif

//--- hw/result_alu.v
`timescale 1ns/1ps
`include "op_consts.vh"
module result_alu (
  // operation and operand
  input  wire [`OP_W-1:0]   op,
  input  wire [`DATA_W-1:0] operand,
  // result
  output reg  [`DATA_W-1:0] result,
  output wire               is_zero
);
  always @* begin
    case (op)
      `OP_COMP_FILE: result = ~operand;
      `OP_DEC_FILE,
      `OP_DEC_SKIP:  result = operand - `DATA_ONE;
      default:       result = `DATA_ZERO;
    endcase
  end
  // RULE13: zero test
  assign is_zero = (result == `DATA_ZERO);
endmodule // result_alu
